// *** rtl/safety_stop_pkg.sv ***
// Constants, types and register map of the safety stop-response block.
// Assumes a single 40 MHz clock and an APB master with 32-bit data.
//
// Contract
// - An internal event triggers a stop; only fail-safe acknowledgment clears it.
// - Cross-check fault or inadmissible speed raises an internal event.
// - Category A stop removes motor torque at once, without braking.
// - Category B stop brakes on quick-stop ramp to standstill, then category A.
// - Torque-controlled motor switches to speed control for category B braking.
// - Braking is ramp-monitored; leaving the ramp aborts into category A.
// - Under deferred stop, a cross-check fault always gives category A at once.
// - Deferred message gives A while torque-off is active, otherwise B.
// - With no function active the message is latched until one is selected; here a fail-safe ack also releases it.
// - Speed monitor counts as active only with filter and hysteresis enabled.
// - Event during motion monitoring gives a deferred stop, not an unconditional one.
// - Safety input pulse 0-1-0 is a fail-safe acknowledgment.
// - Telegram word 0 bit 7 pulse 0-1-0 is a fail-safe acknowledgment.
// - Select then deselect torque-off or controlled stop is a fail-safe ack.
// - Power cycle clears all faults needing fail-safe acknowledgment.
// - Faults need fail-safe acknowledgment, not only the standard one.
// - Speed-below-limit bit sits in the telegram and routes to safety output.

package safety_stop_pkg;

  // -------------------------------------------------------------------------
  // Register offsets (byte addresses)
  // -------------------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] CONFIG_OFFSET = 8'h04;
  localparam logic [7:0] CW0_OFFSET = 8'h08;
  localparam logic [7:0] CW1_OFFSET = 8'h0c;
  localparam logic [7:0] STATUS_OFFSET = 8'h10;
  localparam logic [7:0] SPEED_LIMIT_OFFSET = 8'h14;
  localparam logic [7:0] RAMP_TOL_OFFSET = 8'h18;
  localparam logic [7:0] RAMP_STEP_OFFSET = 8'h1c;
  localparam logic [7:0] STANDSTILL_OFFSET = 8'h20;
  localparam logic [7:0] CAUSE_OFFSET = 8'h24;

  // -------------------------------------------------------------------------
  // Field positions
  // -------------------------------------------------------------------------
  localparam int CTRL_STD_ACK_BIT = 0;
  localparam int CFG_PIN_MODE_BIT = 0;
  localparam int CFG_SPD_FILTER_BIT = 1;
  localparam int CFG_SPD_HYST_BIT = 2;
  localparam int CFG_ROUTE_LSB = 4;
  localparam int CFG_W = 6;
  localparam int CW0_FS_ACK_BIT = 7;
  localparam int CW1_TORQUE_OFF_BIT = 0;
  localparam int CW1_CSTOP_BIT = 1;
  localparam int CW1_LSPEED_BIT = 4;
  localparam int CW1_DIR_BIT = 12;
  localparam int ST_TORQUE_OFF_BIT = 0;
  localparam int ST_EVENT_BIT = 7;
  localparam int ST_SPEED_BELOW_BIT = 15;
  localparam int ST_RAMP_BIT = 16;
  localparam int ST_PENDING_BIT = 17;
  localparam int ST_WAIT_STD_BIT = 18;
  localparam int SPEED_W = 16;

  // -------------------------------------------------------------------------
  // Reset values
  // -------------------------------------------------------------------------
  localparam logic [CFG_W-1:0] CONFIG_RESET = 6'h00;
  localparam logic [31:0] CW0_RESET = 32'h0000_0000;
  localparam logic [31:0] CW1_RESET = 32'h0000_1013;
  localparam logic [SPEED_W-1:0] SPEED_LIMIT_RESET = 16'h0100;
  localparam logic [SPEED_W-1:0] RAMP_TOL_RESET = 16'h0040;
  localparam logic [SPEED_W-1:0] RAMP_STEP_RESET = 16'h0001;
  localparam logic [SPEED_W-1:0] STANDSTILL_RESET = 16'h0004;

  // -------------------------------------------------------------------------
  // Safety output routing codes
  // -------------------------------------------------------------------------
  localparam logic [1:0] ROUTE_EVENT = 2'h0;
  localparam logic [1:0] ROUTE_TORQUE_OFF = 2'h1;
  localparam logic [1:0] ROUTE_SPEED_BELOW = 2'h2;
  localparam logic [1:0] ROUTE_RAMP = 2'h3;

  // -------------------------------------------------------------------------
  // Types
  // -------------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_RUN, ST_STOP_A, ST_STOP_B, ST_PEND_F, ST_WAIT_STD
  } stop_state_type;

  typedef enum logic [1:0] {DET_SEEK, DET_ARMED, DET_AWAY} det_state_type;

  typedef struct packed {
    logic cross_check_fault;
    logic speed_limit_violation;
    logic monitor_msg;
  } fault_in_type;

  typedef struct packed {
    logic torque_off;
    logic quick_stop_ramp;
    logic force_speed_control;
    logic internal_event_flag;
    logic torque_off_active_flag;
    logic ramp_monitor_active_flag;
    logic speed_below_limit_flag;
    logic safety_output;
  } stop_out_type;

endpackage

// *** rtl/level_seq_detect.sv ***
// Three-level sequence detector for fail-safe acknowledgment inputs.
// Assumes its level input is already synchronous to pclk.

`timescale 1ns/1ps
`default_nettype none

module level_seq_detect #(
  parameter logic IDLE_LEVEL = 1'b0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic enable,
  input wire logic level,
  output var logic done
);

  typedef struct packed {
    safety_stop_pkg::det_state_type state;
    logic done;
  } det_reg_type;

  det_reg_type r_reg;
  det_reg_type r_next;

  // -------------------------------------------------------------------------
  // Sequence tracking
  // -------------------------------------------------------------------------
  // Done fires only when the level returns to idle after leaving it, so a
  // sequence cut short never produces a pulse.
  always_comb begin
    r_next = r_reg;
    r_next.done = 1'b0;
    if (!enable) begin
      r_next.state = safety_stop_pkg::DET_SEEK;
    end else begin
      case (r_reg.state)
        safety_stop_pkg::DET_SEEK: begin
          if (level == IDLE_LEVEL) begin
            r_next.state = safety_stop_pkg::DET_ARMED;
          end
        end
        safety_stop_pkg::DET_ARMED: begin
          if (level != IDLE_LEVEL) begin
            r_next.state = safety_stop_pkg::DET_AWAY;
          end
        end
        safety_stop_pkg::DET_AWAY: begin
          if (level == IDLE_LEVEL) begin
            r_next.state = safety_stop_pkg::DET_ARMED;
            r_next.done = 1'b1;
          end
        end
        default: begin
          r_next.state = safety_stop_pkg::DET_SEEK;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= '{state: safety_stop_pkg::DET_SEEK, done: 1'b0};
    end else begin
      r_reg <= r_next;
    end
  end

  assign done = r_reg.done;

endmodule

`default_nettype wire

// *** rtl/safety_stop_response.sv ***
// Safety stop-response and acknowledgment unit with an APB register port.
// Assumes fault inputs, motor speed and run command are synchronous to pclk;
// the safety input pin is asynchronous and is synchronised here.

`timescale 1ns/1ps
`default_nettype none

module safety_stop_response (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [safety_stop_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output var logic [31:0] prdata,
  output var logic pready,
  output var logic pslverr,
  input wire logic safety_input,
  input wire logic run_command_bit,
  input wire logic torque_control_mode,
  input wire logic [safety_stop_pkg::SPEED_W-1:0] motor_speed,
  input wire safety_stop_pkg::fault_in_type fault_in,
  output var safety_stop_pkg::stop_out_type stop_out
);

  localparam int SW = safety_stop_pkg::SPEED_W;
  localparam int NDET = 5;
  // Detector order: safety input 0-1-0, word 0 ack 0-1-0, safety input
  // 1-0-1, torque-off deselect 1-0-1, controlled stop deselect 1-0-1.
  localparam logic [NDET-1:0] DET_IDLE = 5'h1c;

  typedef struct packed {
    logic pin_meta;
    logic pin_sync;
    logic [safety_stop_pkg::CFG_W-1:0] cfg;
    logic [31:0] cw0;
    logic [31:0] cw1;
    logic [SW-1:0] speed_limit;
    logic [SW-1:0] ramp_tol;
    logic [SW-1:0] ramp_step;
    logic [SW-1:0] standstill;
    logic std_ack;
    safety_stop_pkg::stop_state_type stop;
    logic [SW-1:0] envelope;
    logic [2:0] cause;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    safety_stop_pkg::stop_out_type out;
  } state_type;

  state_type r_reg;
  state_type r_next;

  logic [NDET-1:0] det_level;
  logic [NDET-1:0] det_enable;
  logic [NDET-1:0] det_done;
  logic pin_mode;
  logic fs_ack;
  logic torque_off_sel;
  logic spd_mon_active;
  logic motion_active;
  logic any_active;
  logic speed_below;
  logic deferred_now;
  logic [SW:0] env_sum;
  logic [31:0] status_word;
  logic apb_access;

  // -------------------------------------------------------------------------
  // Acknowledgment sources
  // -------------------------------------------------------------------------
  assign pin_mode = r_reg.cfg[safety_stop_pkg::CFG_PIN_MODE_BIT];
  assign det_level = {r_reg.cw1[safety_stop_pkg::CW1_CSTOP_BIT],
                      r_reg.cw1[safety_stop_pkg::CW1_TORQUE_OFF_BIT],
                      r_reg.pin_sync,
                      r_reg.cw0[safety_stop_pkg::CW0_FS_ACK_BIT],
                      r_reg.pin_sync};
  assign det_enable = {1'b1, 1'b1, pin_mode, 1'b1, ~pin_mode};

  genvar gi;
  generate
    for (gi = 0; gi < NDET; gi++) begin : g_det
      level_seq_detect #(
        .IDLE_LEVEL(DET_IDLE[gi])
      ) u_det (
        .pclk(pclk),
        .presetn(presetn),
        .enable(det_enable[gi]),
        .level(det_level[gi]),
        .done(det_done[gi])
      );
    end
  endgenerate

  // Any completed sequence counts; word 0 bit 7 and the safety input in
  // pulse mode, or a select/deselect of torque-off or controlled stop.
  assign fs_ack = |det_done;

  // -------------------------------------------------------------------------
  // Active safety functions
  // -------------------------------------------------------------------------
  // Torque-off is selected by a low deselect bit in word 1, or by a low
  // safety input when that input serves as torque-off deselect.
  assign torque_off_sel =
    ~r_reg.cw1[safety_stop_pkg::CW1_TORQUE_OFF_BIT] |
    (pin_mode & ~r_reg.pin_sync);
  assign spd_mon_active =
    r_reg.cfg[safety_stop_pkg::CFG_SPD_FILTER_BIT] &
    r_reg.cfg[safety_stop_pkg::CFG_SPD_HYST_BIT];
  assign motion_active = ~r_reg.cw1[safety_stop_pkg::CW1_CSTOP_BIT] |
                         ~r_reg.cw1[safety_stop_pkg::CW1_LSPEED_BIT] |
                         ~r_reg.cw1[safety_stop_pkg::CW1_DIR_BIT] |
                         spd_mon_active;
  assign any_active = motion_active | torque_off_sel;
  assign speed_below = spd_mon_active & (motor_speed < r_reg.speed_limit);

  // A speed violation or monitor message goes through the deferred path;
  // a cross-check fault always stops at once.
  assign deferred_now = fault_in.speed_limit_violation |
                        fault_in.monitor_msg;
  assign env_sum = {1'b0, motor_speed} + {1'b0, r_reg.ramp_tol};
  assign apb_access = psel & penable;

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[safety_stop_pkg::ST_TORQUE_OFF_BIT] =
      r_reg.out.torque_off_active_flag;
    status_word[safety_stop_pkg::ST_EVENT_BIT] =
      r_reg.out.internal_event_flag;
    status_word[safety_stop_pkg::ST_SPEED_BELOW_BIT] =
      r_reg.out.speed_below_limit_flag;
    status_word[safety_stop_pkg::ST_RAMP_BIT] =
      r_reg.out.ramp_monitor_active_flag;
    status_word[safety_stop_pkg::ST_PENDING_BIT] =
      (r_reg.stop == safety_stop_pkg::ST_PEND_F);
    status_word[safety_stop_pkg::ST_WAIT_STD_BIT] =
      (r_reg.stop == safety_stop_pkg::ST_WAIT_STD);
  end

  // -------------------------------------------------------------------------
  // Next state
  // -------------------------------------------------------------------------
  always_comb begin
    r_next = r_reg;
    r_next.pin_meta = safety_input;
    r_next.pin_sync = r_reg.pin_meta;
    r_next.std_ack = 1'b0;

    // APB: one wait state, then the answer; writes land on the answer edge.
    if (apb_access && !r_reg.pready) begin
      r_next.pready = 1'b1;
      r_next.pslverr = 1'b0;
      r_next.prdata = 32'h0000_0000;
      case (paddr)
        safety_stop_pkg::CTRL_OFFSET: r_next.prdata = 32'h0000_0000;
        safety_stop_pkg::CONFIG_OFFSET: begin
          r_next.prdata = {26'h0000000, r_reg.cfg};
        end
        safety_stop_pkg::CW0_OFFSET: r_next.prdata = r_reg.cw0;
        safety_stop_pkg::CW1_OFFSET: r_next.prdata = r_reg.cw1;
        safety_stop_pkg::STATUS_OFFSET: r_next.prdata = status_word;
        safety_stop_pkg::SPEED_LIMIT_OFFSET: begin
          r_next.prdata = {16'h0000, r_reg.speed_limit};
        end
        safety_stop_pkg::RAMP_TOL_OFFSET: begin
          r_next.prdata = {16'h0000, r_reg.ramp_tol};
        end
        safety_stop_pkg::RAMP_STEP_OFFSET: begin
          r_next.prdata = {16'h0000, r_reg.ramp_step};
        end
        safety_stop_pkg::STANDSTILL_OFFSET: begin
          r_next.prdata = {16'h0000, r_reg.standstill};
        end
        safety_stop_pkg::CAUSE_OFFSET: begin
          r_next.prdata = {29'h00000000, r_reg.cause};
        end
        default: r_next.pslverr = 1'b1;
      endcase
    end else if (apb_access && r_reg.pready) begin
      r_next.pready = 1'b0;
      r_next.pslverr = 1'b0;
      if (pwrite && !r_reg.pslverr) begin
        case (paddr)
          safety_stop_pkg::CTRL_OFFSET: begin
            r_next.std_ack = pwdata[safety_stop_pkg::CTRL_STD_ACK_BIT];
          end
          safety_stop_pkg::CONFIG_OFFSET: begin
            r_next.cfg = pwdata[safety_stop_pkg::CFG_W-1:0];
          end
          safety_stop_pkg::CW0_OFFSET: r_next.cw0 = pwdata;
          safety_stop_pkg::CW1_OFFSET: r_next.cw1 = pwdata;
          safety_stop_pkg::SPEED_LIMIT_OFFSET: begin
            r_next.speed_limit = pwdata[SW-1:0];
          end
          safety_stop_pkg::RAMP_TOL_OFFSET: r_next.ramp_tol = pwdata[SW-1:0];
          safety_stop_pkg::RAMP_STEP_OFFSET: r_next.ramp_step = pwdata[SW-1:0];
          safety_stop_pkg::STANDSTILL_OFFSET: begin
            r_next.standstill = pwdata[SW-1:0];
          end
          default: r_next.std_ack = 1'b0;
        endcase
      end
    end else begin
      r_next.pready = 1'b0;
      r_next.pslverr = 1'b0;
    end

    // Fault causes: a fail-safe ack clears them, a new event in the same
    // cycle still sets its bit.
    if (fs_ack) begin
      r_next.cause = 3'h0;
    end
    r_next.cause = r_next.cause | {fault_in.monitor_msg,
                                   fault_in.speed_limit_violation,
                                   fault_in.cross_check_fault};

    // Stop reaction.
    case (r_reg.stop)
      safety_stop_pkg::ST_RUN, safety_stop_pkg::ST_WAIT_STD: begin
        if (fault_in.cross_check_fault) begin
          r_next.stop = safety_stop_pkg::ST_STOP_A;
        end else if (deferred_now) begin
          if (torque_off_sel) begin
            r_next.stop = safety_stop_pkg::ST_STOP_A;
          end else if (any_active) begin
            r_next.stop = safety_stop_pkg::ST_STOP_B;
          end else begin
            r_next.stop = safety_stop_pkg::ST_PEND_F;
          end
        end else if (r_reg.stop == safety_stop_pkg::ST_WAIT_STD &&
                     r_reg.std_ack && !run_command_bit) begin
          r_next.stop = safety_stop_pkg::ST_RUN;
        end
      end
      safety_stop_pkg::ST_PEND_F: begin
        // The latched message waits for a function to be selected or for a fail-safe ack.
        if (fault_in.cross_check_fault || torque_off_sel) begin
          r_next.stop = safety_stop_pkg::ST_STOP_A;
        end else if (any_active) begin
          r_next.stop = safety_stop_pkg::ST_STOP_B;
        end else if (fs_ack) begin
          r_next.stop = safety_stop_pkg::ST_WAIT_STD;
        end
      end
      safety_stop_pkg::ST_STOP_B: begin
        if (fault_in.cross_check_fault || torque_off_sel) begin
          r_next.stop = safety_stop_pkg::ST_STOP_A;
        end else if (motor_speed > r_reg.envelope) begin
          r_next.stop = safety_stop_pkg::ST_STOP_A;
        end else if (motor_speed <= r_reg.standstill) begin
          r_next.stop = safety_stop_pkg::ST_STOP_A;
        end
      end
      safety_stop_pkg::ST_STOP_A: begin
        if (fs_ack && !fault_in.cross_check_fault) begin
          r_next.stop = safety_stop_pkg::ST_WAIT_STD;
        end
      end
      default: r_next.stop = safety_stop_pkg::ST_STOP_A;
    endcase

    // Ramp envelope: starts at speed plus tolerance, falls by one step a
    // cycle; the speed must stay under it while braking.
    if (r_next.stop == safety_stop_pkg::ST_STOP_B &&
        r_reg.stop != safety_stop_pkg::ST_STOP_B) begin
      r_next.envelope = env_sum[SW] ? {SW{1'b1}} : env_sum[SW-1:0];
    end else if (r_reg.stop == safety_stop_pkg::ST_STOP_B) begin
      r_next.envelope = (r_reg.envelope > r_reg.ramp_step) ?
        r_reg.envelope - r_reg.ramp_step : {SW{1'b0}};
    end

    // Outputs follow the next state so they change with it.
    r_next.out.torque_off = (r_next.stop == safety_stop_pkg::ST_STOP_A) |
                            (r_next.stop == safety_stop_pkg::ST_WAIT_STD) |
                            torque_off_sel;
    r_next.out.quick_stop_ramp =
      (r_next.stop == safety_stop_pkg::ST_STOP_B);
    r_next.out.force_speed_control =
      (r_next.stop == safety_stop_pkg::ST_STOP_B) &
      torque_control_mode;
    r_next.out.ramp_monitor_active_flag =
      (r_next.stop == safety_stop_pkg::ST_STOP_B);
    r_next.out.internal_event_flag = |r_next.cause;
    r_next.out.torque_off_active_flag = r_next.out.torque_off;
    r_next.out.speed_below_limit_flag = speed_below;
    case (r_reg.cfg[safety_stop_pkg::CFG_ROUTE_LSB +: 2])
      safety_stop_pkg::ROUTE_EVENT: begin
        r_next.out.safety_output = r_next.out.internal_event_flag;
      end
      safety_stop_pkg::ROUTE_TORQUE_OFF: begin
        r_next.out.safety_output = r_next.out.torque_off_active_flag;
      end
      safety_stop_pkg::ROUTE_SPEED_BELOW: begin
        r_next.out.safety_output = speed_below;
      end
      safety_stop_pkg::ROUTE_RAMP: begin
        r_next.out.safety_output = r_next.out.ramp_monitor_active_flag;
      end
      default: r_next.out.safety_output = 1'b0;
    endcase
  end

  // -------------------------------------------------------------------------
  // State register
  // -------------------------------------------------------------------------
  // Power-on reset clears every latched fault and stop state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg.pin_meta <= 1'b0;
      r_reg.pin_sync <= 1'b0;
      r_reg.cfg <= safety_stop_pkg::CONFIG_RESET;
      r_reg.cw0 <= safety_stop_pkg::CW0_RESET;
      r_reg.cw1 <= safety_stop_pkg::CW1_RESET;
      r_reg.speed_limit <= safety_stop_pkg::SPEED_LIMIT_RESET;
      r_reg.ramp_tol <= safety_stop_pkg::RAMP_TOL_RESET;
      r_reg.ramp_step <= safety_stop_pkg::RAMP_STEP_RESET;
      r_reg.standstill <= safety_stop_pkg::STANDSTILL_RESET;
      r_reg.std_ack <= 1'b0;
      r_reg.stop <= safety_stop_pkg::ST_RUN;
      r_reg.envelope <= {SW{1'b0}};
      r_reg.cause <= 3'h0;
      r_reg.pready <= 1'b0;
      r_reg.pslverr <= 1'b0;
      r_reg.prdata <= 32'h0000_0000;
      r_reg.out <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign prdata = r_reg.prdata;
  assign pready = r_reg.pready;
  assign pslverr = r_reg.pslverr;
  assign stop_out = r_reg.out;

endmodule

`default_nettype wire

// *** dv/safety_stop_response_chk.sv ***
// Assertions on the APB answer and the stop outputs of the block.
// Assumes the standstill threshold keeps its reset value.
`timescale 1ns/1ps
`default_nettype none
module safety_stop_response_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic torque_control_mode,
  input wire logic [safety_stop_pkg::SPEED_W-1:0] motor_speed,
  input wire safety_stop_pkg::fault_in_type fault_in,
  input wire safety_stop_pkg::stop_out_type stop_out
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_READY_LATE: assert property (psel && penable && !pready |=> pready)
    else $error("no answer in the second access cycle");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("answer held too long");
  AST_ERR_ALONE: assert property (pslverr |-> pready)
    else $error("error without answer");
  AST_CROSS_STOP: assert property (
    fault_in.cross_check_fault |=> stop_out.torque_off
    && stop_out.internal_event_flag) else $error("cross-check not stopped");
  AST_A_NO_BRAKE: assert property (
    stop_out.torque_off |-> !stop_out.quick_stop_ramp)
    else $error("torque off while braking");
  AST_STANDSTILL: assert property (
    stop_out.quick_stop_ramp &&
    motor_speed <= safety_stop_pkg::STANDSTILL_RESET
    |=> stop_out.torque_off) else $error("no stop at standstill");
  AST_SPEED_MODE: assert property (
    stop_out.quick_stop_ramp && torque_control_mode
    && $stable(torque_control_mode) |-> stop_out.force_speed_control)
    else $error("braking left in torque control");
  AST_RAMP_WATCH: assert property (
    stop_out.quick_stop_ramp |-> stop_out.ramp_monitor_active_flag)
    else $error("braking without ramp monitor");
endmodule
`default_nettype wire

// *** dv/safety_ctl_model.sv ***
// Behavioural safety controller on the safety input and run command.
// Assumes it is stepped from the same clock as the block.
`timescale 1ns/1ps
`default_nettype none
module safety_ctl_model (
  input wire logic pclk,
  output var logic safety_input,
  output var logic run_command_bit
);
  initial {safety_input, run_command_bit} = 2'b01;
  // Each level is held long enough to pass the input synchroniser.
  task automatic drive(input logic pin, input logic v);
    @(posedge pclk);
    if (pin)
      safety_input <= v;
    else
      run_command_bit <= v;
    repeat (5) @(posedge pclk);
  endtask
endmodule
`default_nettype wire

// *** dv/test_safety_stop_response.sv ***
// Self-checking bench of the stop-response block.
// Assumes an APB master here and a controller model on the safety pins.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin num_errors++; \
  $display("MISMATCH %0t got %h expected %h", $time, a, b); end end
module test_safety_stop_response;
  typedef struct {logic err; logic [31:0] d; logic [31:0] m;} exp_type;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, torque_control_mode = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [15:0] motor_speed = 16'h0;
  safety_stop_pkg::fault_in_type fault_in = 3'h0;
  wire logic pready, pslverr, safety_input, run_command_bit;
  wire logic [31:0] prdata;
  wire safety_stop_pkg::stop_out_type stop_out;
  exp_type q[$];
  exp_type e;
  int num_errors = 0;
  int cmp_count = 0;
  always #12.5 pclk = ~pclk;
  safety_ctl_model ctl_u (.pclk(pclk), .safety_input(safety_input),
    .run_command_bit(run_command_bit));
  safety_stop_response dut_u (.*);
  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [31:0] d, input logic [31:0] m);
    if (!wr)
      q.push_back('{a > 8'h24, d, m});
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    {psel, penable} <= 2'b00;
  endtask
  task automatic hit(input logic [2:0] f);
    @(posedge pclk);
    fault_in <= f;
    @(posedge pclk);
    fault_in <= 3'h0;
    repeat (2) @(posedge pclk);
  endtask
  task automatic print_verdict();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      e = q.pop_front();
      `CHK({pslverr, prdata & e.m}, {e.err, e.d & e.m})
    end
  end
  initial begin
    repeat (3000) @(posedge pclk);
    num_errors++;
    print_verdict();
  end
  initial begin
    void'($urandom(32'h11c3));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 8'h0c, 32'h1013, 32'hffff_ffff);
    apb(0, 8'h40, 32'h0, 32'hffff_ffff);
    hit(3'h4);
    `CHK(stop_out[7:4], 4'h9)
    ctl_u.drive(0, 0);
    apb(1, 8'h00, 32'h1, 32'h0);
    apb(0, 8'h10, 32'h81, 32'h40081);
    apb(1, 8'h08, 32'h80, 32'h0);
    apb(1, 8'h08, 32'h0, 32'h0);
    apb(0, 8'h10, 32'h40000, 32'h40000);
    apb(1, 8'h00, 32'h1, 32'h0);
    apb(0, 8'h10, 32'h0, 32'h40081);
    apb(1, 8'h0c, 32'h1003, 32'h0);
    torque_control_mode <= 1'b1;
    motor_speed <= 16'h0200 + 16'($urandom % 64);
    hit(3'h2);
    `CHK(stop_out[7:5], 3'h3)
    motor_speed <= 16'h0;
    repeat (3) @(posedge pclk);
    `CHK(stop_out[7:6], 2'h2)
    apb(1, 8'h0c, 32'h1001, 32'h0);
    apb(1, 8'h0c, 32'h1013, 32'h0);
    apb(0, 8'h10, 32'h40000, 32'h40000);
    apb(1, 8'h00, 32'h1, 32'h0);
    torque_control_mode <= 1'b0;
    apb(1, 8'h04, 32'h2, 32'h0);
    hit(3'h1);
    apb(0, 8'h10, 32'h20000, 32'h20001);
    motor_speed <= 16'h0080;
    apb(1, 8'h04, 32'h6, 32'h0);
    repeat (2) @(posedge pclk);
    `CHK(stop_out, 8'h57)
    motor_speed <= 16'h0;
    apb(1, 8'h0c, 32'h1012, 32'h0);
    apb(1, 8'h0c, 32'h1013, 32'h0);
    apb(1, 8'h00, 32'h1, 32'h0);
    apb(0, 8'h10, 32'h0, 32'h40081);
    hit(3'h4);
    ctl_u.drive(1, 1);
    apb(1, 8'h00, 32'h1, 32'h0);
    apb(0, 8'h10, 32'h81, 32'h40081);
    ctl_u.drive(1, 0);
    apb(0, 8'h10, 32'h40000, 32'h40000);
    apb(1, 8'h04, 32'h11, 32'h0);
    ctl_u.drive(1, 1);
    hit(3'h4);
    `CHK(stop_out[1:0], 2'h1)
    ctl_u.drive(1, 0);
    ctl_u.drive(1, 1);
    apb(0, 8'h10, 32'h40000, 32'h40000);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 8'h10, 32'h0, 32'h40081);
    ctl_u.drive(0, 1);
    print_verdict();
  end
endmodule
bind safety_stop_response safety_stop_response_chk chk_u (.*);
`default_nettype wire
